// ==== dv/chip_reset_sequencer_asserts.sv ====
// assertion checker for the chip reset sequencer
`timescale 1ns/1ps
`default_nettype none
module chip_reset_sequencer_asserts #(
    parameter int unsigned BIST_CYCLES  = 400,
    parameter int unsigned LONG_CYCLES  = 300,
    parameter int unsigned SHORT_CYCLES = 200
) (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       power_on_reset_input_n,
    input wire logic       reset_pin_in,
    input wire logic       reset_pin_out,
    input wire logic       reset_pin_oe_n,
    input wire logic       boot_done,
    input wire logic       core_reset_n,
    input wire logic       app_start,
    input wire logic [2:0] seq_kind,
    input wire logic       seq_busy
);
    logic [23:0] cnt_ff;
    logic [23:0] nxt_cnt;
    // saturates: a pull begun in reset or by power loss is never timed
    always_comb begin
        nxt_cnt = cnt_ff;
        if (reset_pin_oe_n) nxt_cnt = 24'h000000;
        else if (!power_on_reset_input_n) nxt_cnt = 24'hFFFFFF;
        else if (cnt_ff != 24'hFFFFFF) nxt_cnt = cnt_ff + 24'h000001;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) cnt_ff <= 24'hFFFFFF;
        else cnt_ff <= nxt_cnt;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence pin_let_go;
        $rose(reset_pin_oe_n) && cnt_ff != 24'hFFFFFF;
    endsequence
    pin_low_only_a: assert property (reset_pin_out == 1'b0)
        else $error("pin output not low");
    pull_in_seq_a: assert property (!reset_pin_oe_n |-> seq_busy)
        else $error("pin pulled outside a sequence");
    core_after_pin_a: assert property ($rose(core_reset_n)
        |-> reset_pin_in && $past(reset_pin_in, 2))
        else $error("core reset left before pin high");
    busy_mirror_a: assert property (seq_busy == !core_reset_n)
        else $error("busy and core reset disagree");
    core_over_pull_a: assert property (!reset_pin_oe_n
        |=> !core_reset_n)
        else $error("core reset left while pin still pulled");
    app_gated_a: assert property ($rose(app_start)
        |-> $past(boot_done) && core_reset_n)
        else $error("application start without boot");
    app_in_reset_a: assert property (!core_reset_n |-> !app_start)
        else $error("application start during reset");
    por_holds_a: assert property (!power_on_reset_input_n [*5]
        |-> !core_reset_n && !reset_pin_oe_n)
        else $error("power-on input low but not in reset");
    short_len_a: assert property (pin_let_go ##0 seq_kind == 3'h4
        |-> cnt_ff >= SHORT_CYCLES - 1 && cnt_ff <= SHORT_CYCLES + 2)
        else $error("short sequence length wrong");
    long_len_a: assert property (pin_let_go
        ##0 (seq_kind == 3'h1 || seq_kind == 3'h3)
        |-> cnt_ff >= LONG_CYCLES - 1 && cnt_ff <= LONG_CYCLES + 2)
        else $error("long sequence length wrong");
    bist_len_a: assert property (pin_let_go
        ##0 (seq_kind == 3'h0 || seq_kind == 3'h2)
        |-> cnt_ff >= BIST_CYCLES - 1 && cnt_ff <= BIST_CYCLES + 2)
        else $error("self-test sequence length wrong");
endmodule
bind chip_reset_sequencer chip_reset_sequencer_asserts #(
    .BIST_CYCLES(BIST_CYCLES), .LONG_CYCLES(LONG_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES)
) i_chk (.sys_clk, .rst_n, .power_on_reset_input_n, .reset_pin_in,
    .reset_pin_out, .reset_pin_oe_n, .boot_done, .core_reset_n,
    .app_start, .seq_kind, .seq_busy);
`default_nettype wire

// ==== dv/chip_reset_sequencer_bench.sv ====
// self-checking bench for the chip reset sequencer
`timescale 1ns/1ps
`default_nettype none
module chip_reset_sequencer_bench;
    localparam int BC = 400;
    localparam int LC = 300;
    localparam int SC = 200;
    logic sys_clk = 1'b0;
    logic rst_n, power_on_reset_input_n, reset_pin_in, reset_pin_out;
    logic reset_pin_oe_n, logic_self_test_en, memory_self_test_en;
    logic destr_req, func_long_req, func_short_req, func_src_drive_en;
    logic boot_done, core_reset_n, app_start, seq_busy, hold_low;
    logic [2:0] seq_kind;
    int miscompares = 0;
    int samples_checked = 0;
    int n;
    always #5 sys_clk = ~sys_clk;
    chip_reset_sequencer #(.BIST_CYCLES(BC), .LONG_CYCLES(LC),
        .SHORT_CYCLES(SC), .FINAL_CYCLES(20)) i_dut (.sys_clk, .rst_n,
        .power_on_reset_input_n, .reset_pin_in, .reset_pin_out,
        .reset_pin_oe_n, .logic_self_test_en, .memory_self_test_en,
        .destr_req, .func_long_req, .func_short_req, .func_src_drive_en,
        .boot_done, .core_reset_n, .app_start, .seq_kind, .seq_busy);
    ext_reset_gen i_gen (.reset_pin_out, .reset_pin_oe_n, .hold_low,
        .pin(reset_pin_in));
    task automatic test_done;
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input int lo, hi,
                       input logic [15:0] got);
        samples_checked++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d",
                     nm, lo, hi, got);
        end
    endtask
    // counts pulled cycles while waiting; bounded so a hang still reports
    task automatic wt(input logic v);
        for (int w = 0; seq_busy !== v; w++) begin
            if (w > 3000) begin
                miscompares++;
                $display("CHECK FAILED busy expected %0b seen %0b", v, seq_busy);
                test_done();
            end
            @(negedge sys_clk);
            if (reset_pin_oe_n === 1'b0) n++;
        end
    endtask
    task automatic boot;
        repeat (4) @(negedge sys_clk);
        chk("app_early", 0, 0, {15'h0000, app_start});
        @(posedge sys_clk) boot_done <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("app_start", 1, 1, {15'h0000, app_start});
    endtask
    task automatic sq(input logic d, l, s, b, e, input int k, c);
        @(posedge sys_clk);
        logic_self_test_en <= b;
        func_src_drive_en <= e;
        boot_done <= 1'b0;
        @(posedge sys_clk);
        destr_req <= d;
        func_long_req <= l;
        func_short_req <= s;
        @(posedge sys_clk);
        {destr_req, func_long_req, func_short_req} <= 3'h0;
        n = 0;
        wt(1'b1);
        wt(1'b0);
        chk("kind", k, k, {13'h0000, seq_kind});
        chk("pulled", c ? c - 1 : 0, c ? c + 2 : 0, 16'(n));
        boot();
    endtask
    task automatic t_power_up;
        repeat (4) @(negedge sys_clk);
        chk("pulled", 0, 0, {15'h0000, reset_pin_oe_n});
        chk("core_rst", 0, 0, {15'h0000, core_reset_n});
        chk("pin_out", 0, 0, {15'h0000, reset_pin_out});
        @(posedge sys_clk) power_on_reset_input_n <= 1'b1;
        n = 0;
        wt(1'b0);
        chk("kind", 1, 1, {13'h0000, seq_kind});
        chk("pulled", LC, LC + 5, 16'(n));
        boot();
    endtask
    // power lost mid-run: pin pulled and core held, then a fresh start
    task automatic t_por_drop;
        @(posedge sys_clk);
        memory_self_test_en <= 1'b0;
        boot_done <= 1'b0;
        power_on_reset_input_n <= 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("por_pull", 0, 0, {15'h0000, reset_pin_oe_n});
        chk("por_core", 0, 0, {15'h0000, core_reset_n});
        chk("por_app", 0, 0, {15'h0000, app_start});
        @(posedge sys_clk) power_on_reset_input_n <= 1'b1;
        n = 0;
        wt(1'b0);
        chk("kind", 1, 1, {13'h0000, seq_kind});
        chk("pulled", LC, LC + 5, 16'(n));
        boot();
    endtask
    task automatic t_destr;
        sq(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1, LC);
        sq(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 0, BC);
    endtask
    task automatic t_func;
        sq(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3, LC);
        sq(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 4, SC);
        sq(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4, 0);
    endtask
    // external hold outlasts the device pull, so the core must wait
    task automatic t_ext_hold;
        @(posedge sys_clk);
        memory_self_test_en <= 1'b1;
        boot_done <= 1'b0;
        @(posedge sys_clk) hold_low <= 1'b1;
        repeat (BC + 100) @(negedge sys_clk);
        chk("held", 1, 1, {15'h0000, seq_busy});
        chk("let_go", 1, 1, {15'h0000, reset_pin_oe_n});
        chk("kind", 2, 2, {13'h0000, seq_kind});
        @(posedge sys_clk) hold_low <= 1'b0;
        wt(1'b0);
        boot();
    endtask
    initial begin
        rst_n = 1'b0;
        power_on_reset_input_n = 1'b0;
        {logic_self_test_en, memory_self_test_en, destr_req} = 3'h0;
        {func_long_req, func_short_req, func_src_drive_en} = 3'h0;
        boot_done = 1'b0;
        hold_low = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_power_up();
        t_destr();
        t_func();
        t_ext_hold();
        t_por_drop();
        test_done();
    end
endmodule
`default_nettype wire

// ==== dv/ext_reset_gen.sv ====
// board reset generator and pull-up on the shared reset pin
`timescale 1ns/1ps
`default_nettype none
module ext_reset_gen (
    input  wire logic reset_pin_out,
    input  wire logic reset_pin_oe_n,
    input  wire logic hold_low,
    output var  logic pin
);
    // open drain: nobody drives high, so the pull-up wins when all let go
    always_comb begin
        if (!reset_pin_oe_n) pin = reset_pin_out;
        else if (hold_low) pin = 1'b0;
        else pin = 1'b1;
    end
endmodule
`default_nettype wire

// ==== rtl/chip_reset_sequencer.sv ====
// chip-level reset sequencer with open-drain reset pin
`timescale 1ns/1ps
`default_nettype none
module chip_reset_sequencer #(
    parameter int unsigned BIST_CYCLES  = rst_seq_pkg::BIST_CYC,
    parameter int unsigned LONG_CYCLES  = rst_seq_pkg::LONG_CYC,
    parameter int unsigned SHORT_CYCLES = rst_seq_pkg::SHORT_CYC,
    parameter int unsigned FINAL_CYCLES = rst_seq_pkg::FINAL_CYC
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     power_on_reset_input_n,
    input  wire logic                     reset_pin_in,
    output var  logic                     reset_pin_out,
    output var  logic                     reset_pin_oe_n,
    input  wire logic                     logic_self_test_en,
    input  wire logic                     memory_self_test_en,
    input  wire logic                     destr_req,
    input  wire logic                     func_long_req,
    input  wire logic                     func_short_req,
    input  wire logic                     func_src_drive_en,
    input  wire logic                     boot_done,
    output var  logic                     core_reset_n,
    output var  logic                     app_start,
    output var  logic [2:0]               seq_kind,
    output var  logic                     seq_busy
);
    import rst_seq_pkg::*;

    logic por_sync;
    logic pin_sync;
    logic por_seen_ff;
    logic nxt_por_seen;

    seq_state_e state_ff;
    seq_state_e nxt_state;
    cnt_t       cnt_ff;
    cnt_t       nxt_cnt;
    seq_kind_e  kind_ff;
    seq_kind_e  nxt_kind;
    logic       drive_ff;
    logic       nxt_drive;
    logic       core_rst_ff;
    logic       nxt_core_rst;
    logic       app_ff;
    logic       nxt_app;
    logic       bist_sel;
    cnt_t       main_len;
    logic       nxt_reset_pin_out;
    logic       nxt_reset_pin_oe_n;
    logic       nxt_core_reset_n;
    logic       nxt_app_start;
    logic [2:0] nxt_seq_kind;
    logic       nxt_seq_busy;

    // pins come from the board, so pass two flops first
    sync2 #(.RESET_VAL(1'b0)) u_por_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       (power_on_reset_input_n),
        .q       (por_sync)
    );

    sync2 #(.RESET_VAL(1'b0)) u_pin_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       (reset_pin_in),
        .q       (pin_sync)
    );

    assign bist_sel = logic_self_test_en | memory_self_test_en;

    // main phase length excludes the final phase
    always_comb begin
        case (kind_ff)
            KIND_DESTR_BIST: main_len = cnt_t'(BIST_CYCLES - FINAL_CYCLES);
            KIND_EXT_BIST:   main_len = cnt_t'(BIST_CYCLES - FINAL_CYCLES);
            KIND_DESTR:      main_len = cnt_t'(LONG_CYCLES - FINAL_CYCLES);
            KIND_FUNC_LONG:  main_len = cnt_t'(LONG_CYCLES - FINAL_CYCLES);
            KIND_FUNC_SHORT: main_len = cnt_t'(SHORT_CYCLES - FINAL_CYCLES);
            default:         main_len = cnt_t'(LONG_CYCLES - FINAL_CYCLES);
        endcase
    end

    always_comb begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_kind     = kind_ff;
        nxt_drive    = drive_ff;
        nxt_core_rst = core_rst_ff;
        nxt_app      = app_ff;
        nxt_por_seen = por_seen_ff;
        case (state_ff)
            ST_IDLE: begin
                // wait for power-on release, then start
                if (por_sync) begin
                    nxt_por_seen = 1'b1;
                    nxt_state    = ST_MAIN;
                    nxt_cnt      = '0;
                    nxt_kind     = bist_sel ? KIND_DESTR_BIST : KIND_DESTR;
                    nxt_drive    = 1'b1;
                    nxt_core_rst = 1'b1;
                end
            end
            ST_MAIN: begin
                nxt_cnt = cnt_ff + cnt_t'(1);
                if (cnt_ff >= main_len - cnt_t'(1)) begin
                    nxt_state = ST_FINAL;
                    nxt_cnt   = '0;
                end
            end
            ST_FINAL: begin
                nxt_cnt = cnt_ff + cnt_t'(1);
                if (cnt_ff >= cnt_t'(FINAL_CYCLES - 1)) begin
                    nxt_drive = 1'b0;
                    nxt_state = ST_PIN_WAIT;
                    nxt_cnt   = '0;
                end
            end
            ST_PIN_WAIT: begin
                // outside generator may stretch the low time
                if (pin_sync) begin
                    nxt_core_rst = 1'b0;
                    nxt_state    = ST_BOOT;
                end
            end
            ST_BOOT: begin
                if (boot_done) begin
                    nxt_app   = 1'b1;
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // any new reset cause restarts, destructive first
                if (destr_req) begin
                    nxt_state    = ST_MAIN;
                    nxt_kind     = bist_sel ? KIND_DESTR_BIST : KIND_DESTR;
                    nxt_drive    = 1'b1;
                end else if (!pin_sync) begin
                    nxt_state    = ST_MAIN;
                    nxt_kind     = bist_sel ? KIND_EXT_BIST : KIND_FUNC_LONG;
                    nxt_drive    = 1'b1;
                end else if (func_long_req || func_short_req) begin
                    nxt_state    = ST_MAIN;
                    nxt_kind     = func_long_req ? KIND_FUNC_LONG
                                                 : KIND_FUNC_SHORT;
                    nxt_drive    = func_src_drive_en;
                end
                if (destr_req || !pin_sync || func_long_req
                    || func_short_req) begin
                    nxt_cnt      = '0;
                    nxt_core_rst = 1'b1;
                    nxt_app      = 1'b0;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // losing power-on again aborts everything
        if (por_seen_ff && !por_sync) begin
            nxt_state    = ST_IDLE;
            nxt_por_seen = 1'b0;
            nxt_drive    = 1'b1;
            nxt_core_rst = 1'b1;
            nxt_app      = 1'b0;
            nxt_cnt      = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= ST_IDLE;
            cnt_ff      <= '0;
            kind_ff     <= KIND_DESTR;
            drive_ff    <= 1'b1;
            core_rst_ff <= 1'b1;
            app_ff      <= 1'b0;
            por_seen_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            kind_ff     <= nxt_kind;
            drive_ff    <= nxt_drive;
            core_rst_ff <= nxt_core_rst;
            app_ff      <= nxt_app;
            por_seen_ff <= nxt_por_seen;
        end
    end

    // open drain: data is always low, only the enable moves
    // a high is never driven; the board pull-up makes it
    always_comb begin
        nxt_reset_pin_out  = 1'b0;
        nxt_reset_pin_oe_n = ~nxt_drive;
        nxt_core_reset_n   = ~nxt_core_rst;
        nxt_app_start      = nxt_app;
        nxt_seq_kind       = nxt_kind;
        nxt_seq_busy       = nxt_core_rst;
    end

    // fed from the next state so pins move with it, not a cycle late
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_pin_out  <= 1'b0;
            reset_pin_oe_n <= 1'b0;
            core_reset_n   <= 1'b0;
            app_start      <= 1'b0;
            seq_kind       <= KIND_DESTR;
            seq_busy       <= 1'b1;
        end else begin
            reset_pin_out  <= nxt_reset_pin_out;
            reset_pin_oe_n <= nxt_reset_pin_oe_n;
            core_reset_n   <= nxt_core_reset_n;
            app_start      <= nxt_app_start;
            seq_kind       <= nxt_seq_kind;
            seq_busy       <= nxt_seq_busy;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/rst_seq_pkg.sv ====
// constants and types shared by the chip reset sequencer
package rst_seq_pkg;

    localparam int unsigned CLK_MHZ        = 100;
    // sequence lengths as printed, in microseconds
    localparam int unsigned T_BIST_MIN_US  = 25000;
    localparam int unsigned T_BIST_MAX_US  = 50000;
    localparam int unsigned T_LONG_MIN_US  = 50;
    localparam int unsigned T_LONG_MAX_US  = 90;
    localparam int unsigned T_SHORT_MIN_US = 2;
    localparam int unsigned T_SHORT_MAX_US = 7;
    // cycle counts: aim at the minimum, rounded up
    localparam int unsigned BIST_CYC  = T_BIST_MIN_US * CLK_MHZ;
    localparam int unsigned LONG_CYC  = T_LONG_MIN_US * CLK_MHZ;
    localparam int unsigned SHORT_CYC = T_SHORT_MIN_US * CLK_MHZ;
    // share of a sequence spent in the final phase, in cycles
    localparam int unsigned FINAL_CYC = 100;

    localparam int CNT_W = 22;
    typedef logic [CNT_W-1:0] cnt_t;

    typedef enum logic [2:0] {
        KIND_DESTR_BIST = 3'h0,
        KIND_DESTR      = 3'h1,
        KIND_EXT_BIST   = 3'h2,
        KIND_FUNC_LONG  = 3'h3,
        KIND_FUNC_SHORT = 3'h4
    } seq_kind_e;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_MAIN    = 3'h1,
        ST_FINAL   = 3'h2,
        ST_PIN_WAIT = 3'h3,
        ST_BOOT    = 3'h4,
        ST_RUN     = 3'h5
    } seq_state_e;

endpackage

// ==== rtl/sync2.sv ====
// two-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic d,
    output var  logic q
);
    logic meta_ff;
    logic nxt_meta;
    logic nxt_q;

    always_comb begin
        nxt_meta = d;
        nxt_q    = meta_ff;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RESET_VAL;
            q       <= RESET_VAL;
        end else begin
            meta_ff <= nxt_meta;
            q       <= nxt_q;
        end
    end
endmodule
`default_nettype wire
